// ---- rtl/adc_out_consts.svh ----
`ifndef ADC_OUT_CONSTS_SVH
`define ADC_OUT_CONSTS_SVH

// Output word layout
`define WORD_BITS 24
`define RES_BITS 21
`define BIT_DONE_N 23
`define BIT_FILLER 22
`define BIT_SIGN 21
`define LAST_FALL_IDX 5'h17

// Offset binary codes of the sign and result bits together
`define CODE_ZERO 22'h200000
`define CODE_POS_FS 22'h300000
`define CODE_NEG_CLAMP 22'h0fffff
`define FS_LSB 24'sh100000

// Master clock
`define MCLK_HZ 40000000
`define MCLK_PERIOD_NS 25

// Internal conversion clock for each notch: 2560 times the line frequency
`define NOTCH_DIV 2560
`define NOTCH60_HZ 60
`define NOTCH50_HZ 50
`define DIV60_CYC (`MCLK_HZ / (`NOTCH60_HZ * `NOTCH_DIV))
`define DIV50_CYC (`MCLK_HZ / (`NOTCH50_HZ * `NOTCH_DIV))

// Conversion length in conversion clock periods
`define CONV_TICKS 10278

// Serial clock is the conversion clock divided by this
`define SCK_DIV 8

// External clock detection: 5 kHz minimum, so silence longer than 250 us means absent
`define EXT_MIN_HZ 5000
`define EXT_TIMEOUT_US 250
`define EXT_TIMEOUT_CYC ((`EXT_TIMEOUT_US * 1000) / `MCLK_PERIOD_NS)

`endif

// ---- rtl/adc_out_pkg.sv ----
package adc_out_pkg;

    typedef enum logic [1:0] {
        ST_CONVERT = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OUTPUT = 2'b11
    } conv_state_t;

    typedef struct packed {
        logic done_n;
        logic filler_bit;
        logic sign_flag;
        logic [20:0] result;
    } out_word_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } sck_event_t;

endpackage

// ---- rtl/sample_fifo.sv ----
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    assign out_valid_out = (wr_ptr_r != rd_ptr_r);
    assign in_ready_out = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

// ---- rtl/conv_clock_source.sv ----
`timescale 1ns/1ps
`include "adc_out_consts.svh"
module conv_clock_source #(
    parameter int TIMEOUT_CYC = `EXT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Select pin, level or external clock
    input wire logic sel_in,
    // Conversion clock
    output logic tick_out,
    output logic ext_mode_out
);
    logic sel_prev_r;
    logic [15:0] idle_cnt_r;
    logic armed_r;
    logic ext_r;
    logic [8:0] div_cnt_r;
    logic [8:0] div_last;
    logic tick_r;
    logic sel_rise;
    logic sel_edge;
    logic timed_out;

    assign sel_rise = sel_in && !sel_prev_r;
    assign sel_edge = sel_in != sel_prev_r;
    assign timed_out = idle_cnt_r >= 16'(TIMEOUT_CYC - 1);
    // High selects the 50 Hz notch, low the 60 Hz one
    assign div_last = sel_in ? 9'(`DIV50_CYC - 1) : 9'(`DIV60_CYC - 1);
    assign tick_out = tick_r;
    assign ext_mode_out = ext_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_prev_r <= 1'b0;
        end else begin
            sel_prev_r <= sel_in;
        end
    end

    // Edges reset the silence count; only rises arm, so duty cycle is irrelevant
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_cnt_r <= '0;
            armed_r <= 1'b0;
            ext_r <= 1'b0;
        end else if (sel_edge) begin
            idle_cnt_r <= '0;
            if (sel_rise) begin
                armed_r <= 1'b1;
                if (armed_r) begin
                    ext_r <= 1'b1;
                end
            end
        end else if (timed_out) begin
            armed_r <= 1'b0;
            ext_r <= 1'b0;
        end else begin
            idle_cnt_r <= idle_cnt_r + 16'h0001;
        end
    end

    // Divider restarts when external clock takes over; a switch only stretches one tick
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (ext_r) begin
            div_cnt_r <= '0;
            tick_r <= sel_rise;
        end else if (div_cnt_r >= div_last) begin
            div_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 9'h001;
            tick_r <= 1'b0;
        end
    end
endmodule

// ---- rtl/adc_result_serial_output.sv ----
`timescale 1ns/1ps
`include "adc_out_consts.svh"
// Functional notes
// - Result leaves as 24 bits: three status bits, then 21 result bits, MSB first.
// - First bit is done_n: high while converting, low once done; shown when selected.
// - Second bit is the filler bit, always low.
// - Sign flag high for positive or zero input, low for negative.
// - Sign and result top bit both high means overrange, both low underrange.
// - Sign with result bits is offset binary; zero gives sign high, rest zero.
// - Chip select high: serial output floats, serial clock edges ignored.
// - Host samples done_n on first rising edge; filler bit goes on first fall.
// - Last bit driven on 23rd falling edge, host latches it on 24th rise.
// - 24th falling edge drives output high and starts a new conversion.
// - Selected and idle, output falls low the moment a conversion completes.
// - Above full scale clamps to +FS code; below clamps to -FS minus one LSB.
// - Internal oscillator tuned for 60 Hz with select low, 50 Hz when high.
// - Select change disturbs at most the conversion then in progress.
// - External clock on the select pin detected, internal oscillator then unused.
// - External clock drives the conversion, notch at its frequency over 2560.
// - Without external clock the internal oscillator returns automatically.
// - Clock source switch spoils at most the running conversion.
// - Internal serial clock mode drives the clock at conversion clock over 8.
// - Reset and each chip select fall pick external mode if clock low.
// - Chip select rising after the first rise aborts output, starts conversion.
module adc_result_serial_output #(
    parameter int CONV_TICKS = `CONV_TICKS,
    parameter int EXT_TIMEOUT_CYC = `EXT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RSTN_IN,
    // Samples from the front end, signed LSB units
    input wire logic SAMPLE_VALID_IN,
    input wire logic [23:0] SAMPLE_IN,
    output logic SAMPLE_READY_OUT,
    // Serial pins
    input wire logic CSN_IN,
    input wire logic SCK_IN,
    output logic SCK_OUT,
    output logic SCK_OE_OUT,
    output logic SDO_OUT,
    output logic SDO_OE_OUT,
    // Conversion clock select pin
    input wire logic REJECTION_CLOCK_SELECT_IN,
    // Status
    output logic CONVERTING_OUT,
    output logic EXT_CONV_CLK_OUT,
    output logic EXT_SCK_MODE_OUT
);
    adc_out_pkg::conv_state_t state_r;
    adc_out_pkg::out_word_t word_r;
    adc_out_pkg::sck_event_t sck_ev;
    logic [23:0] shreg_r;
    logic [4:0] fall_cnt_r;
    logic rise_seen_r;
    logic [13:0] conv_cnt_r;
    logic conv_full;
    logic ext_sck_r;
    logic por_pend_r;
    logic cs_n_prev_r;
    logic sck_prev_r;
    logic isck_r;
    logic [1:0] isck_div_r;
    logic isck_run;
    logic isck_toggle;
    logic sdo_r;
    logic sdo_nxt;
    logic sdo_oe_r;
    logic sck_oe_r;
    logic cs_fall;
    logic conv_tick;
    logic ext_conv;
    logic fifo_valid;
    logic [23:0] fifo_data;
    logic fifo_pop;

    // Offset binary with clamping; zero lands on sign high
    function automatic adc_out_pkg::out_word_t format_result(input logic [23:0] sample);
        logic signed [23:0] v;
        logic [21:0] code;
        adc_out_pkg::out_word_t w;
        v = signed'(sample);
        if (v >= `FS_LSB) begin
            code = `CODE_POS_FS;
        end else if (v < -`FS_LSB) begin
            code = `CODE_NEG_CLAMP;
        end else begin
            code = 22'(v) + `CODE_ZERO;
        end
        w.done_n = 1'b0;
        w.filler_bit = 1'b0;
        w.sign_flag = code[21];
        w.result = code[20:0];
        return w;
    endfunction

    conv_clock_source #(
        .TIMEOUT_CYC(EXT_TIMEOUT_CYC)
    ) u_clk_src (
        .clk_in(MCLK_IN),
        .rst_n_in(RSTN_IN),
        .sel_in(REJECTION_CLOCK_SELECT_IN),
        .tick_out(conv_tick),
        .ext_mode_out(ext_conv)
    );

    // Samples wait here while the converter sleeps; the front end stalls only once all 16 entries are full
    sample_fifo #(
        .WIDTH(24),
        .DEPTH(16)
    ) u_fifo (
        .clk_in(MCLK_IN),
        .rst_n_in(RSTN_IN),
        .in_valid_in(SAMPLE_VALID_IN),
        .in_data_in(SAMPLE_IN),
        .in_ready_out(SAMPLE_READY_OUT),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(fifo_pop)
    );

    assign cs_fall = cs_n_prev_r && !CSN_IN;
    assign conv_full = conv_cnt_r >= 14'(CONV_TICKS - 1);
    assign fifo_pop = (state_r == adc_out_pkg::ST_CONVERT) && conv_full && fifo_valid;

    // Serial clock edges from the pin or from our own divider, dropped while deselected
    assign isck_run = !ext_sck_r && !CSN_IN && (state_r == adc_out_pkg::ST_OUTPUT);
    assign isck_toggle = isck_run && conv_tick && (isck_div_r == 2'h3);

    always_comb begin
        sck_ev.rise = 1'b0;
        sck_ev.fall = 1'b0;
        if (!CSN_IN) begin
            if (ext_sck_r) begin
                sck_ev.rise = SCK_IN && !sck_prev_r;
                sck_ev.fall = !SCK_IN && sck_prev_r;
            end else begin
                sck_ev.rise = isck_toggle && !isck_r;
                sck_ev.fall = isck_toggle && isck_r;
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cs_n_prev_r <= 1'b1;
            sck_prev_r <= 1'b0;
        end else begin
            cs_n_prev_r <= CSN_IN;
            sck_prev_r <= SCK_IN;
        end
    end

    // Mode caught on the first edge after reset release and at each select fall
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            por_pend_r <= 1'b1;
            ext_sck_r <= 1'b0;
        end else if (por_pend_r || cs_fall) begin
            por_pend_r <= 1'b0;
            ext_sck_r <= !SCK_IN;
        end
    end

    // Own serial clock: half period is four conversion ticks
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            isck_r <= 1'b0;
            isck_div_r <= '0;
        end else if (!isck_run) begin
            isck_r <= 1'b0;
            isck_div_r <= '0;
        end else if (conv_tick) begin
            isck_div_r <= isck_div_r + 2'h1;
            if (isck_toggle) begin
                isck_r <= !isck_r;
            end
        end
    end

    // Conversion length counted in conversion clock ticks
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            conv_cnt_r <= '0;
        end else if (state_r != adc_out_pkg::ST_CONVERT) begin
            conv_cnt_r <= '0;
        end else if (conv_tick && !conv_full) begin
            conv_cnt_r <= conv_cnt_r + 14'h0001;
        end
    end

    // Result held until the next conversion completes
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            word_r <= '0;
        end else if (fifo_pop) begin
            word_r <= format_result(fifo_data);
        end
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_r <= adc_out_pkg::ST_CONVERT;
            shreg_r <= '0;
            fall_cnt_r <= '0;
            rise_seen_r <= 1'b0;
        end else begin
            case (state_r)
                adc_out_pkg::ST_CONVERT: begin
                    if (fifo_pop) begin
                        state_r <= adc_out_pkg::ST_SLEEP;
                    end
                end
                adc_out_pkg::ST_SLEEP: begin
                    if (!CSN_IN) begin
                        state_r <= adc_out_pkg::ST_OUTPUT;
                        shreg_r <= word_r;
                        fall_cnt_r <= '0;
                        rise_seen_r <= 1'b0;
                    end
                end
                adc_out_pkg::ST_OUTPUT: begin
                    if (CSN_IN) begin
                        // Before any rise the result survives for a later read
                        if (rise_seen_r) begin
                            state_r <= adc_out_pkg::ST_CONVERT;
                        end else begin
                            state_r <= adc_out_pkg::ST_SLEEP;
                        end
                    end else begin
                        if (sck_ev.rise) begin
                            rise_seen_r <= 1'b1;
                        end
                        if (sck_ev.fall && rise_seen_r) begin
                            shreg_r <= {shreg_r[22:0], 1'b0};
                            fall_cnt_r <= fall_cnt_r + 5'h01;
                            if (fall_cnt_r == `LAST_FALL_IDX) begin
                                state_r <= adc_out_pkg::ST_CONVERT;
                            end
                        end
                    end
                end
                default: begin
                    state_r <= adc_out_pkg::ST_CONVERT;
                end
            endcase
        end
    end

    // Outside the output state the pin shows done_n live, high while converting
    always_comb begin
        if (state_r == adc_out_pkg::ST_OUTPUT) begin
            sdo_nxt = shreg_r[`BIT_DONE_N];
        end else begin
            sdo_nxt = (state_r == adc_out_pkg::ST_CONVERT);
        end
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sdo_r <= 1'b1;
            sdo_oe_r <= 1'b0;
            sck_oe_r <= 1'b0;
        end else begin
            sdo_r <= sdo_nxt;
            sdo_oe_r <= !CSN_IN;
            sck_oe_r <= !CSN_IN && !ext_sck_r;
        end
    end

    assign SDO_OUT = sdo_r;
    assign SDO_OE_OUT = sdo_oe_r;
    assign SCK_OUT = isck_r;
    assign SCK_OE_OUT = sck_oe_r;
    assign CONVERTING_OUT = (state_r == adc_out_pkg::ST_CONVERT);
    assign EXT_CONV_CLK_OUT = ext_conv;
    assign EXT_SCK_MODE_OUT = ext_sck_r;
endmodule

// ---- test/adc_out_assertions.sv ----
`timescale 1ns/1ps
module adc_out_checker #(
    parameter int CONV_TICKS = 20,
    parameter int EXT_TIMEOUT_CYC = 50
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RSTN_IN,
    // Watched pins
    input wire logic SAMPLE_READY_OUT,
    input wire logic CSN_IN,
    input wire logic SCK_IN,
    input wire logic SCK_OUT,
    input wire logic SCK_OE_OUT,
    input wire logic SDO_OUT,
    input wire logic SDO_OE_OUT,
    input wire logic REJECTION_CLOCK_SELECT_IN,
    input wire logic CONVERTING_OUT,
    input wire logic EXT_CONV_CLK_OUT,
    input wire logic EXT_SCK_MODE_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);
    logic pin_d_r;
    logic rise_seen_r;
    logic sel_d_r;
    int idle_r;
    wire pin = SCK_OE_OUT ? SCK_OUT : SCK_IN;
    // First serial clock rise seen in this frame
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pin_d_r <= 1'b0;
            rise_seen_r <= 1'b0;
        end else begin
            pin_d_r <= pin;
            rise_seen_r <= !CSN_IN && !CONVERTING_OUT && (rise_seen_r || (pin && !pin_d_r));
        end
    end
    // Saturating count of cycles since the select pin last changed
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sel_d_r <= 1'b0;
            idle_r <= 0;
        end else begin
            sel_d_r <= REJECTION_CLOCK_SELECT_IN;
            if (REJECTION_CLOCK_SELECT_IN != sel_d_r) idle_r <= 0;
            else if (idle_r < 100000) idle_r <= idle_r + 1;
        end
    end
    a_cs_high_float: assert property (CSN_IN |=> !SDO_OE_OUT)
        else $error("data pin driven while deselected");
    a_cs_high_noclk: assert property (CSN_IN |=> !SCK_OE_OUT)
        else $error("clock pin driven while deselected");
    a_eoc_on_done: assert property ($fell(CONVERTING_OUT) && !CSN_IN |-> ##[1:2] !SDO_OUT)
        else $error("end of conversion not shown on data pin");
    a_busy_shows_high: assert property (
        CONVERTING_OUT && $past(CONVERTING_OUT, 3) && !CSN_IN |-> SDO_OUT)
        else $error("data pin low while converting");
    a_word_end_high: assert property ($rose(CONVERTING_OUT) && !CSN_IN |-> ##[0:3] SDO_OUT)
        else $error("data pin not high after last bit");
    a_abort_restart: assert property ($rose(CSN_IN) && rise_seen_r |-> ##[1:4] CONVERTING_OUT)
        else $error("abort did not start a conversion");
    a_sleep_keeps: assert property (
        $rose(CSN_IN) && !rise_seen_r && !CONVERTING_OUT |=> !CONVERTING_OUT [*4])
        else $error("early deselect lost the result");
    a_mode_pick: assert property (
        $fell(CSN_IN) |-> ##2 (EXT_SCK_MODE_OUT == !$past(SCK_IN, 2)))
        else $error("serial clock mode wrong after select");
    a_ext_clk_lost: assert property (
        idle_r > EXT_TIMEOUT_CYC + 8 |-> !EXT_CONV_CLK_OUT)
        else $error("external conversion clock kept after silence");
    c_ext: cover property ($rose(EXT_CONV_CLK_OUT));
    c_full: cover property ($fell(SAMPLE_READY_OUT));
    c_abort: cover property ($rose(CSN_IN) && rise_seen_r);
endmodule

bind adc_result_serial_output adc_out_checker #(
    .CONV_TICKS(CONV_TICKS), .EXT_TIMEOUT_CYC(EXT_TIMEOUT_CYC)) chk (
    .MCLK_IN, .RSTN_IN, .SAMPLE_READY_OUT, .CSN_IN, .SCK_IN, .SCK_OUT, .SCK_OE_OUT,
    .SDO_OUT, .SDO_OE_OUT, .REJECTION_CLOCK_SELECT_IN, .CONVERTING_OUT,
    .EXT_CONV_CLK_OUT, .EXT_SCK_MODE_OUT);

// ---- test/host_reader.sv ----
`timescale 1ns/1ps
module host_reader (
    // Clock and data pin
    input wire logic clk_in,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    // Select and clock pins
    output logic csn_out,
    output logic sck_out
);
    localparam int HALF = 6;
    initial begin
        csn_out = 1'b1;
        sck_out = 1'b0;
    end
    task automatic select(input logic v);
        @(posedge clk_in);
        csn_out <= v;
    endtask
    // Parked high stands for a released pin with pull-up
    task automatic park(input logic v);
        @(posedge clk_in);
        sck_out <= v;
    endtask
    // Undriven data reads as unknown so it never matches
    task automatic shift(input int nb, output logic [23:0] word);
        word = 24'h000000;
        for (int k = 0; k < nb; k++) begin
            @(negedge clk_in);
            word = {word[22:0], sdo_oe_in ? sdo_in : 1'bx};
            @(posedge clk_in);
            sck_out <= 1'b1;
            repeat (HALF) @(posedge clk_in);
            sck_out <= 1'b0;
            repeat (HALF) @(posedge clk_in);
        end
    endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`include "adc_out_consts.svh"
module testbench;
    localparam int CT = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic vld = 1'b0;
    logic sel = 1'b0;
    logic ext_run = 1'b0;
    logic [23:0] smp = 24'h000000;
    logic rdy, sck_o, sck_oe, sdo, sdo_oe, conv, ext_clk, ext_sck;
    wire csn;
    wire host_sck;
    wire sck_pin = sck_oe ? sck_o : host_sck;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 74;
    int c;
    int n = 0;
    logic v;
    logic [23:0] w;
    logic [23:0] e;
    logic [23:0] exp_q[$];
    logic [23:0] corner[8] = '{24'h000000, 24'hffffff, 24'h0fffff, 24'h100000,
        24'hf00000, 24'hefffff, 24'h7fffff, 24'h800000};

    always #12.5 clk = ~clk;
    // External conversion clock, ten cycles a period
    always begin
        repeat (5) @(posedge clk);
        if (ext_run) sel <= ~sel;
    end

    adc_result_serial_output #(.CONV_TICKS(CT), .EXT_TIMEOUT_CYC(50)) dut (
        .MCLK_IN(clk), .RSTN_IN(rstn), .SAMPLE_VALID_IN(vld), .SAMPLE_IN(smp),
        .SAMPLE_READY_OUT(rdy), .CSN_IN(csn), .SCK_IN(sck_pin), .SCK_OUT(sck_o),
        .SCK_OE_OUT(sck_oe), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe),
        .REJECTION_CLOCK_SELECT_IN(sel), .CONVERTING_OUT(conv),
        .EXT_CONV_CLK_OUT(ext_clk), .EXT_SCK_MODE_OUT(ext_sck));
    host_reader host (.clk_in(clk), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .csn_out(csn),
        .sck_out(host_sck));

    function automatic logic [23:0] expect_word(input logic [23:0] s);
        if ($signed(s) >= `FS_LSB) return {2'b00, `CODE_POS_FS};
        if ($signed(s) < -`FS_LSB) return {2'b00, `CODE_NEG_CLAMP};
        return {2'b00, s[21:0] + `CODE_ZERO};
    endfunction

    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int lo, input int hi);
        total_checks++;
        if (c < lo || c > hi) begin
            fail_count++;
            $display("[ERR] %0t duration %0d", $time, c);
        end
    endtask

    task automatic wait_on(ref logic s, input logic v, input int lim);
        c = 0;
        while (s !== v) begin
            @(negedge clk);
            c++;
            if (c > lim) begin
                fail_count++;
                $display("[ERR] %0t wait timed out", $time);
                print_verdict();
            end
        end
    endtask

    task automatic read_cmp(input int lo, input int hi);
        host.select(1'b0);
        // Data pin is enabled one clock after the select is seen
        repeat (3) @(posedge clk);
        wait_on(sdo, 1'b0, 20000);
        chk_rng(lo, hi);
        host.shift(24, w);
        check(w, exp_q.pop_front());
        wait_on(sdo, 1'b1, 4);
        check({23'h0, conv}, 24'h000001);
        host.select(1'b1);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        check({19'h0, sdo_oe, sck_oe, conv, ext_clk, rdy}, 24'h000005);
        @(posedge clk);
        rstn <= 1'b1;
        // Corner codes first, then random in-range values
        // Random idle gaps in the sample stream; forced on late so the loop ends
        for (int i = 0; n < 16; i++) begin
            w = $random(seed);
            v = (n < 8) || w[23] || (i > 40);
            w = (n < 8) ? corner[n] : {{3{w[20]}}, w[20:0]};
            @(negedge clk);
            check({23'h0, rdy}, 24'h000001);
            @(posedge clk);
            vld <= v;
            smp <= w;
            if (v) begin
                exp_q.push_back(expect_word(w));
                n++;
            end
        end
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        check({23'h0, rdy}, 24'h000000);
        wait_on(conv, 1'b0, 20000);
        chk_rng(CT * `DIV60_CYC - 300, CT * `DIV60_CYC + 50);
        // Changing the notch in sleep must leave this result intact
        @(posedge clk);
        sel <= 1'b1;
        read_cmp(0, 20);
        // Clock pulses while deselected are ignored
        repeat (10) host.shift(1, e);
        // Conversion began at the last fall, some 140 clocks before this wait starts
        read_cmp((CT - 2) * `DIV50_CYC - 200, (CT - 1) * `DIV50_CYC);
        @(posedge clk);
        ext_run <= 1'b1;
        wait_on(ext_clk, 1'b1, 400);
        // Deselect before the first rise keeps the result
        wait_on(conv, 1'b0, 2000);
        host.select(1'b0);
        host.select(1'b1);
        repeat (4) @(negedge clk);
        check({23'h0, conv}, 24'h000000);
        read_cmp(0, 20);
        // Abort after five bits
        host.select(1'b0);
        wait_on(sdo, 1'b0, 2000);
        host.shift(5, w);
        host.select(1'b1);
        e = exp_q.pop_front();
        check({19'h0, w[4:0]}, {19'h0, e[23:19]});
        wait_on(conv, 1'b1, 8);
        while (exp_q.size() > 1) read_cmp(CT * 10 - 40, CT * 10 + 20);
        @(posedge clk);
        ext_run <= 1'b0;
        repeat (8) @(posedge clk);
        sel <= 1'b0;
        wait_on(ext_clk, 1'b0, 200);
        // Internal serial clock: pin left high at the select fall
        host.park(1'b1);
        host.select(1'b0);
        repeat (3) @(negedge clk);
        check({22'h0, ext_sck, sck_oe}, 24'h000001);
        wait_on(sck_o, 1'b1, 10000);
        wait_on(sck_o, 1'b0, 1100);
        check(c[23:0], 24'(4 * `DIV60_CYC));
        host.select(1'b1);
        wait_on(sdo_oe, 1'b0, 3);
        wait_on(conv, 1'b1, 8);
        check({23'h0, sck_oe}, 24'h000000);
        print_verdict();
    end
endmodule
